// ==== src/dcsw_top.sv ====
// drive control word decoder and state word composer

// write walk, one line per cycle
// - c0: strobe high, word and valid bit on the bus
// - c1: stored word and bit 7 history updated
// - c2: decoded commands and trip reset pulse out
// - c3: trip reset low again, levels stay
// read walk, one line per cycle
// - c0: read strobe and register number
// - c1: answer flag and read data for one cycle

// timing notes
// - a word without valid bit leaves no trace
// - strobe without valid bit is not a take
// - bit 7 history moves only with taken words
// - state word follows drive state one cycle late
// - read data is the state word at its register
// - read data and state word agree in one cycle
// - any other register number answers zero
// - no wait states, back to back requests allowed

// settings
// - each stop and start function has its own mode
// - modes: inputs only, bus only, and, or
// - preset and setup selects combine bit by bit
// - reverse has its own mode as well
// - relay selects gate the two relay bits
// - multi-setup enables the setup select

// hazards and limits
// - after reset the stored word is all zero
// - so in bus and or modes coast, brake and quick stop start active
// - in bus and and modes a valid word must come before any start
// - freeze drops while coast or brake is active
// - ramp stops are masked while frozen
// - slow down wins over speed up while frozen
// - setup select is zero outside multi-setup
// - relays need their selection bit as well
// - reverse follows the input in digital mode
// - trip reset needs a fall between two rises
// - no buffering beyond the stored word
// - all inputs but the async reset are taken as synchronous
`timescale 1ns/100ps
module dcsw_top
  import dcsw_pkg::*;
(
  input wire logic i_sys_clk, // system clock
  input wire logic i_rst, // async reset, active high
  input wire logic i_cmd_wr, // control word write strobe
  input wire logic [15:0] i_cmd_word, // written control word
  input wire logic [15:0] i_reg_addr, // holding register read address
  input wire logic i_reg_rd, // register read strobe
  input wire dcsw_pkg::dcsw_cfg_t i_cfg, // source and option settings
  input wire dcsw_pkg::dcsw_din_t i_din, // digital input functions
  input wire dcsw_pkg::dcsw_state_t i_state, // drive state
  input wire logic i_link_ok, // bus option link alive
  output dcsw_pkg::dcsw_cmd_t o_cmd, // decoded commands
  output logic [15:0] o_state_word, // live state word
  output logic [15:0] o_rd_data, // register read data
  output logic o_rd_valid // read answer pulse
);
  import dcsw_pkg::*;

  // stored word and trip reset edge state
  logic [15:0] cmd_word; // last accepted control word
  logic [15:0] next_cmd_word;
  logic reset_prev; // bit 7 as last accepted
  logic next_reset_prev;
  logic reset_pulse; // one-cycle trip reset
  logic next_reset_pulse;
  // next values of the output registers
  dcsw_cmd_t next_cmd;
  logic [15:0] next_state_word;
  logic [15:0] next_rd_data;
  logic next_rd_valid;
  // combined active-level functions
  logic act_coast;
  logic act_start;
  logic act_qstop;
  logic act_brake;
  logic act_rev;

  // bit-pick helper for combined pairs
  // one combining mode applied to both bits
  // shared by preset and setup selects
  function automatic logic [1:0] pick2(input dcsw_src_t src,
                                       input logic [1:0] bus,
                                       input logic [1:0] din);
    case (src)
      DCSW_SRC_DIGITAL: pick2 = din;
      DCSW_SRC_BUS: pick2 = bus;
      DCSW_SRC_AND: pick2 = bus & din;
      default: pick2 = bus | din;
    endcase
  endfunction : pick2

  // one combiner per stop or start function
  // every pair works on active levels, so the
  // low-active bits are inverted on the way in
  // coast: active when bit low
  dcsw_combine u_coast (
    .i_src(i_cfg.coast),
    .i_bus(~cmd_word[CW_COAST_N]),
    .i_din(~i_din.coast_n),
    .o_act(act_coast)
  );
  // start permission: active when bit high
  // a missing start permission means ramp stop
  dcsw_combine u_start (
    .i_src(i_cfg.start),
    .i_bus(cmd_word[CW_RAMP_START]),
    .i_din(i_din.start),
    .o_act(act_start)
  );
  // quick stop: active when bit low
  // masked later while the output is frozen
  dcsw_combine u_qstop (
    .i_src(i_cfg.qstop),
    .i_bus(~cmd_word[CW_QSTOP_N]),
    .i_din(~i_din.qstop_n),
    .o_act(act_qstop)
  );
  // dc brake: active when bit low
  // also one of the stops that ends a freeze
  dcsw_combine u_brake (
    .i_src(i_cfg.brake),
    .i_bus(~cmd_word[CW_DC_BRAKE_N]),
    .i_din(~i_din.brake_n),
    .o_act(act_brake)
  );
  // reverse: digital by default
  // bus bit counts only in bus, and, or modes
  dcsw_combine u_rev (
    .i_src(i_cfg.reverse),
    .i_bus(cmd_word[CW_REVERSE]),
    .i_din(i_din.reverse),
    .o_act(act_rev)
  );

  // accept control word only with valid bit
  // an ignored word keeps the stored word and history
  // so a later valid word sees the right bit 7 edge
  always_comb
  begin
    next_cmd_word = cmd_word;
    next_reset_prev = reset_prev;
    next_reset_pulse = 1'b0;
    if (i_cmd_wr && i_cmd_word[CW_DATA_VALID])
    begin
      // taken word replaces the stored one
      next_cmd_word = i_cmd_word;
      next_reset_prev = i_cmd_word[CW_RESET];
      // rising edge of reset bit only
      next_reset_pulse = i_cmd_word[CW_RESET] & ~reset_prev;
    end
  end

  // command word registers
  // cleared by reset, loaded on every edge
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      // stored word cleared, no pending pulse
      cmd_word <= CMD_WORD_RESET;
      reset_prev <= 1'b0;
      reset_pulse <= 1'b0;
    end
    else
    begin
      cmd_word <= next_cmd_word;
      reset_prev <= next_reset_prev;
      reset_pulse <= next_reset_pulse;
    end
  end

  // decode commands
  // every field from the stored word, digital inputs and settings
  // stored-word levels hold until the next taken word
  // trip reset is the registered one-cycle pulse
  always_comb
  begin
    next_cmd = '0;
    // preset reference, bit 1 msb
    next_cmd.preset_sel = pick2(i_cfg.preset,
      {cmd_word[CW_REF_MSB], cmd_word[CW_REF_LSB]}, i_din.preset);
    // stop functions
    next_cmd.dc_brake = act_brake;
    next_cmd.coast = act_coast;
    // freeze holds unless coast or brake stops it
    next_cmd.freeze = ~cmd_word[CW_FREEZE_N] & ~act_coast
                      & ~act_brake;
    // while frozen, ramp stops are masked
    next_cmd.quick_stop = act_qstop & ~next_cmd.freeze;
    next_cmd.ramp_stop = ~act_start & ~next_cmd.freeze;
    // only inputs move the frozen frequency
    next_cmd.freeze_up = next_cmd.freeze & i_din.speed_up
                         & ~i_din.slow_down;
    next_cmd.freeze_down = next_cmd.freeze & i_din.slow_down;
    // trip reset pulse, then plain followers of the stored word
    next_cmd.trip_reset = reset_pulse;
    next_cmd.jog = cmd_word[CW_JOG];
    next_cmd.ramp_set2 = cmd_word[CW_RAMP_SEL];
    // relays only when their function selects the word
    next_cmd.relay_a = cmd_word[CW_RELAY_A] & i_cfg.relay_a_sel;
    next_cmd.relay_b = cmd_word[CW_RELAY_B] & i_cfg.relay_b_sel;
    // setup only in multi-setup mode
    if (i_cfg.multi_setup)
    begin
      next_cmd.setup_sel = pick2(i_cfg.setup,
        {cmd_word[CW_SETUP_MSB], cmd_word[CW_SETUP_LSB]},
        i_din.setup);
    end
    next_cmd.reverse = act_rev;
  end

  // compose state word
  // all zero while the bus option link is lost
  // bit 5 stays zero, it is not used
  always_comb
  begin
    next_state_word = STATE_WORD_RESET;
    if (i_link_ok)
    begin
      // ready and fault bits
      next_state_word[SW_CTRL_READY] = i_state.ctrl_ready;
      next_state_word[SW_DRIVE_READY] = i_state.drive_ready;
      next_state_word[SW_ENABLED] = i_state.enabled;
      next_state_word[SW_TRIP] = i_state.tripped;
      next_state_word[SW_ERROR] = i_state.error;
      next_state_word[SW_TRIPLOCK] = i_state.triplock;
      // warning, speed match, bus control, limits
      next_state_word[SW_WARNING] = i_state.warning;
      next_state_word[SW_SPEED_EQ] = i_state.speed_eq;
      next_state_word[SW_BUS_CTRL] = i_state.bus_possible;
      next_state_word[SW_FREQ_OK] = i_state.freq_ok;
      // start signal or nonzero output
      next_state_word[SW_IN_OPER] = i_state.in_oper | act_start;
      // overtemperature, voltage, torque, timers
      next_state_word[SW_OVERTEMP] = i_state.overtemp;
      next_state_word[SW_VOLTAGE] = i_state.voltage;
      next_state_word[SW_TORQUE] = i_state.torque;
      next_state_word[SW_TIMER] = i_state.timer;
    end
  end

  // register read answer
  // one answer per strobe, no wait states
  // only the state word register returns data
  always_comb
  begin
    next_rd_valid = i_reg_rd;
    next_rd_data = 16'h0000;
    if (i_reg_rd && i_reg_addr == STATE_WORD_REG)
    begin
      // same value the state word takes next
      next_rd_data = next_state_word;
    end
  end

  // output registers
  // every output comes straight from a flop
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      // all outputs idle low
      o_cmd <= '0;
      o_state_word <= STATE_WORD_RESET;
      o_rd_data <= 16'h0000;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_cmd <= next_cmd;
      o_state_word <= next_state_word;
      o_rd_data <= next_rd_data;
      o_rd_valid <= next_rd_valid;
    end
  end
endmodule : dcsw_top

// ==== src/dcsw_pkg.sv ====
// package for the drive control and status word interpreter
package dcsw_pkg;
  // control word bit positions
  localparam int CW_REF_LSB = 0;
  localparam int CW_REF_MSB = 1;
  localparam int CW_DC_BRAKE_N = 2;
  localparam int CW_COAST_N = 3;
  localparam int CW_QSTOP_N = 4;
  localparam int CW_FREEZE_N = 5;
  localparam int CW_RAMP_START = 6;
  localparam int CW_RESET = 7;
  localparam int CW_JOG = 8;
  localparam int CW_RAMP_SEL = 9;
  localparam int CW_DATA_VALID = 10;
  localparam int CW_RELAY_A = 11;
  localparam int CW_RELAY_B = 12;
  localparam int CW_SETUP_LSB = 13;
  localparam int CW_SETUP_MSB = 14;
  localparam int CW_REVERSE = 15;
  // status word bit positions
  localparam int SW_CTRL_READY = 0;
  localparam int SW_DRIVE_READY = 1;
  localparam int SW_ENABLED = 2;
  localparam int SW_TRIP = 3;
  localparam int SW_ERROR = 4;
  localparam int SW_TRIPLOCK = 6;
  localparam int SW_WARNING = 7;
  localparam int SW_SPEED_EQ = 8;
  localparam int SW_BUS_CTRL = 9;
  localparam int SW_FREQ_OK = 10;
  localparam int SW_IN_OPER = 11;
  localparam int SW_OVERTEMP = 12;
  localparam int SW_VOLTAGE = 13;
  localparam int SW_TORQUE = 14;
  localparam int SW_TIMER = 15;
  // holding register number of the state word
  localparam logic [15:0] STATE_WORD_REG = 16'hc418;
  // reset values
  localparam logic [15:0] CMD_WORD_RESET = 16'h0000;
  localparam logic [15:0] STATE_WORD_RESET = 16'h0000;

  // how a bus bit combines with its digital input twin
  typedef enum logic [1:0] {
    DCSW_SRC_DIGITAL,
    DCSW_SRC_BUS,
    DCSW_SRC_AND,
    DCSW_SRC_OR
  } dcsw_src_t;

  // per-function source selection
  typedef struct packed {
    dcsw_src_t coast;
    dcsw_src_t start;
    dcsw_src_t qstop;
    dcsw_src_t preset;
    dcsw_src_t setup;
    dcsw_src_t reverse;
    dcsw_src_t brake;
    logic relay_a_sel;
    logic relay_b_sel;
    logic multi_setup;
  } dcsw_cfg_t;

  // matching digital input functions, active high except coast_n, qstop_n and brake_n
  typedef struct packed {
    logic coast_n;
    logic start;
    logic qstop_n;
    logic brake_n;
    logic [1:0] preset;
    logic [1:0] setup;
    logic reverse;
    logic speed_up;
    logic slow_down;
  } dcsw_din_t;

  // decoded commands to the motor control
  typedef struct packed {
    logic [1:0] preset_sel;
    logic dc_brake;
    logic coast;
    logic quick_stop;
    logic freeze;
    logic ramp_stop;
    logic trip_reset;
    logic jog;
    logic ramp_set2;
    logic relay_a;
    logic relay_b;
    logic [1:0] setup_sel;
    logic reverse;
    logic freeze_up;
    logic freeze_down;
  } dcsw_cmd_t;

  // drive state inputs to the status word
  typedef struct packed {
    logic ctrl_ready;
    logic drive_ready;
    logic enabled;
    logic tripped;
    logic error;
    logic triplock;
    logic warning;
    logic speed_eq;
    logic bus_possible;
    logic freq_ok;
    logic in_oper;
    logic overtemp;
    logic voltage;
    logic torque;
    logic timer;
  } dcsw_state_t;
endpackage : dcsw_pkg

// ==== src/dcsw_combine.sv ====
// combines one bus command bit with its digital input twin
`timescale 1ns/100ps
module dcsw_combine
  import dcsw_pkg::*;
(
  input wire dcsw_pkg::dcsw_src_t i_src, // combining mode
  input wire logic i_bus, // bus bit, active level
  input wire logic i_din, // digital input, active level
  output logic o_act // combined active level
);
  // mode select
  always_comb
  begin
    case (i_src)
      DCSW_SRC_DIGITAL: o_act = i_din;
      DCSW_SRC_BUS: o_act = i_bus;
      DCSW_SRC_AND: o_act = i_bus & i_din;
      default: o_act = i_bus | i_din;
    endcase
  end
endmodule : dcsw_combine

// ==== verification/dcsw_properties.sv ====
// assertion checker for the control and state word block
`timescale 1ns/100ps
module dcsw_properties
  import dcsw_pkg::*;
(
  input wire logic i_sys_clk, // clock
  input wire logic i_rst, // async reset
  input wire logic i_cmd_wr, // write strobe
  input wire logic [15:0] i_cmd_word, // written word
  input wire logic [15:0] i_reg_addr, // read address
  input wire logic i_reg_rd, // read strobe
  input wire dcsw_pkg::dcsw_cfg_t i_cfg, // settings
  input wire dcsw_pkg::dcsw_state_t i_state, // drive state
  input wire logic i_link_ok, // link alive
  input wire dcsw_pkg::dcsw_cmd_t o_cmd, // commands
  input wire logic [15:0] o_state_word, // state word
  input wire logic [15:0] o_rd_data, // read data
  input wire logic o_rd_valid // read answer
);
  logic last7, next_last7; // reset bit of last accepted word
  logic [15:0] exp_sw, next_exp_sw; // state word less bit 11
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // edge history and expected state word
  always_comb
  begin
    next_last7 = last7;
    if (i_cmd_wr && i_cmd_word[CW_DATA_VALID])
      next_last7 = i_cmd_word[CW_RESET];
    next_exp_sw = 16'h0000;
    if (i_link_ok)
      next_exp_sw = {i_state.timer, i_state.torque, i_state.voltage,
        i_state.overtemp, 1'b0, i_state.freq_ok, i_state.bus_possible,
        i_state.speed_eq, i_state.warning, i_state.triplock, 1'b0,
        i_state.error, i_state.tripped, i_state.enabled,
        i_state.drive_ready, i_state.ctrl_ready};
  end
  // registers only
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
    begin
      last7 <= 1'b0;
      exp_sw <= 16'h0000;
    end
    else
    begin
      last7 <= next_last7;
      exp_sw <= next_exp_sw;
    end
  sequence take_s; i_cmd_wr && i_cmd_word[CW_DATA_VALID]; endsequence
  sequence drop_s; i_cmd_wr && !i_cmd_word[CW_DATA_VALID]; endsequence
  sequence rise_s; take_s ##0 (i_cmd_word[CW_RESET] && !last7); endsequence
  chk_jog_follow: assert property (
    take_s |-> ##2 o_cmd.jog == $past(i_cmd_word[CW_JOG], 2))
    else $error("jog does not follow word");
  chk_ramp_pair: assert property (
    take_s |-> ##2 o_cmd.ramp_set2 == $past(i_cmd_word[CW_RAMP_SEL], 2))
    else $error("ramp pair does not follow word");
  chk_relay_gate: assert property (
    take_s |-> ##2 o_cmd.relay_a == ($past(i_cmd_word[CW_RELAY_A], 2)
      && i_cfg.relay_a_sel) && o_cmd.relay_b ==
      ($past(i_cmd_word[CW_RELAY_B], 2) && i_cfg.relay_b_sel))
    else $error("relay drive wrong");
  chk_setup_pick: assert property (
    take_s ##0 i_cfg.setup == DCSW_SRC_BUS |-> ##2 o_cmd.setup_sel ==
      (i_cfg.multi_setup ? $past(i_cmd_word[14:13], 2) : 2'h0))
    else $error("setup select wrong");
  chk_word_ignore: assert property (
    drop_s |-> ##2 $stable(o_cmd.jog) && $stable(o_cmd.ramp_set2))
    else $error("invalid word acted upon");
  chk_reset_pulse: assert property (
    rise_s |-> ##2 o_cmd.trip_reset ##1 !o_cmd.trip_reset)
    else $error("trip reset pulse missing");
  chk_reset_cause: assert property (
    o_cmd.trip_reset |-> $past(i_cmd_wr && i_cmd_word[CW_DATA_VALID]
      && i_cmd_word[CW_RESET] && !last7, 2))
    else $error("trip reset without rising bit");
  chk_state_map: assert property (
    (o_state_word & 16'hf7ff) == exp_sw)
    else $error("state word mapping wrong");
  chk_link_clear: assert property (
    !i_link_ok |=> o_state_word == 16'h0000)
    else $error("state word not cleared");
  chk_read_answer: assert property (
    i_reg_rd |=> o_rd_valid && o_rd_data == (($past(i_reg_addr) ==
      STATE_WORD_REG) ? o_state_word : 16'h0000))
    else $error("read answer wrong");
  chk_rd_only: assert property (
    o_rd_valid |-> $past(i_reg_rd))
    else $error("read answer without request");
endmodule : dcsw_properties

// ==== verification/dcsw_master.sv ====
// fieldbus master model: writes control words, reads registers
`timescale 1ns/100ps
module dcsw_master (
  input wire logic i_sys_clk, // system clock
  output logic o_wr, // control word strobe
  output logic [15:0] o_word, // control word
  output logic o_rd, // read strobe
  output logic [15:0] o_addr // register number
);
  // idle bus at time zero
  initial
  begin
    o_wr = 1'b0;
    o_word = 16'h0000;
    o_rd = 1'b0;
    o_addr = 16'h0000;
  end
  // whole word in one strobe; released lines show the inverse
  task automatic write(input logic [15:0] w);
    @(posedge i_sys_clk);
    o_wr <= 1'b1;
    o_word <= w;
    @(posedge i_sys_clk);
    o_wr <= 1'b0;
    o_word <= ~w;
  endtask : write
  // one register read strobe
  task automatic read(input logic [15:0] a);
    @(posedge i_sys_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_sys_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
  endtask : read
endmodule : dcsw_master

// ==== verification/test_drive_control_status_word.sv ====
// self-checking bench for the control and state word block
`timescale 1ns/100ps
module test_drive_control_status_word;
  import dcsw_pkg::*;
  logic i_sys_clk, i_rst, i_link_ok, i_cmd_wr, i_reg_rd, o_rd_valid;
  logic [15:0] i_cmd_word, i_reg_addr, o_state_word, o_rd_data;
  dcsw_cfg_t i_cfg; // settings
  dcsw_din_t i_din; // digital inputs
  dcsw_state_t i_state; // drive state
  dcsw_cmd_t o_cmd; // commands
  int errors, n_tests; // counters
  logic [31:0] x = 32'h23; // random state
  logic [15:0] ew, w, a, exp_q[$]; // accepted word, notes
  logic last7, rise; // trip reset edge model
  logic e_st, e_co, e_qs, e_br, e_fz; // expected active levels
  logic [15:0] g, e; // seen and expected words
  dcsw_top i_dcsw_top (.i_sys_clk, .i_rst, .i_cmd_wr, .i_cmd_word,
    .i_reg_addr, .i_reg_rd, .i_cfg, .i_din, .i_state, .i_link_ok, .o_cmd,
    .o_state_word, .o_rd_data, .o_rd_valid);
  dcsw_master i_dcsw_master (.i_sys_clk, .o_wr(i_cmd_wr),
    .o_word(i_cmd_word), .o_rd(i_reg_rd), .o_addr(i_reg_addr));
  // xorshift generator
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // bus bit and input twin under one combining mode
  function automatic logic cb(input dcsw_src_t m, input logic b,
    input logic d);
    return m == DCSW_SRC_DIGITAL ? d : m == DCSW_SRC_BUS ? b :
      m == DCSW_SRC_AND ? (b & d) : (b | d);
  endfunction : cb
  // expected state word with combined start
  function automatic logic [15:0] sw_of(input dcsw_state_t s, logic st);
    return {s.timer, s.torque, s.voltage, s.overtemp, s.in_oper | st,
      s.freq_ok, s.bus_possible, s.speed_eq, s.warning, s.triplock, 1'b0,
      s.error, s.tripped, s.enabled, s.drive_ready, s.ctrl_ready};
  endfunction : sw_of
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic wrap_up;
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // clock
  initial
  begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  // read answers against oldest note
  always @(posedge i_sys_clk)
    if (o_rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(16'(o_rd_valid), 16'h0000);
      else
        chk(o_rd_data, exp_q.pop_front());
    end
  // watchdog
  initial
  begin
    repeat (3000) @(posedge i_sys_clk);
    errors++;
    wrap_up();
  end
  // main sequence
  initial
  begin
    i_rst = 1'b1;
    i_cfg = {{7{DCSW_SRC_BUS}}, 3'b111};
    i_din = '0;
    i_state = '0;
    i_link_ok = 1'b1;
    ew = 16'h0000;
    last7 = 1'b0;
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 60; k++)
    begin
      @(posedge i_sys_clk);
      // second reset in mid-run
      if (k == 30)
      begin
        i_rst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        ew = 16'h0000;
        last7 = 1'b0;
      end
      x = xs(x);
      i_state <= x[14:0];
      i_din <= x[31:21];
      i_link_ok <= x[20:18] != 3'h0;
      x = xs(x);
      i_cfg <= {x[13:0], x[16:14]}; // random modes and options
      x = xs(x);
      w = x[15:0];
      rise = w[CW_DATA_VALID] & w[CW_RESET] & !last7;
      if (w[CW_DATA_VALID])
      begin
        ew = w;
        last7 = w[CW_RESET];
      end
      i_dcsw_master.write(w);
      // commands and trip pulse show one edge after the take
      @(posedge i_sys_clk);
      #1;
      e_st = cb(i_cfg.start, ew[6], i_din.start);
      e_co = cb(i_cfg.coast, !ew[3], !i_din.coast_n);
      e_qs = cb(i_cfg.qstop, !ew[4], !i_din.qstop_n);
      e_br = cb(i_cfg.brake, !ew[2], !i_din.brake_n);
      e_fz = !ew[5] & !e_co & !e_br;
      g = {o_cmd.preset_sel, o_cmd.dc_brake, o_cmd.coast, o_cmd.quick_stop,
        o_cmd.freeze, o_cmd.ramp_stop, o_cmd.jog, o_cmd.ramp_set2,
        o_cmd.relay_a, o_cmd.relay_b, o_cmd.setup_sel, o_cmd.reverse,
        o_cmd.freeze_up, o_cmd.freeze_down};
      e = {cb(i_cfg.preset, ew[1], i_din.preset[1]),
        cb(i_cfg.preset, ew[0], i_din.preset[0]), e_br, e_co,
        e_qs & !e_fz, e_fz, !e_st & !e_fz, ew[8], ew[9],
        ew[11] & i_cfg.relay_a_sel, ew[12] & i_cfg.relay_b_sel,
        i_cfg.multi_setup ? {cb(i_cfg.setup, ew[14], i_din.setup[1]),
        cb(i_cfg.setup, ew[13], i_din.setup[0])} : 2'h0,
        cb(i_cfg.reverse, ew[15], i_din.reverse),
        e_fz & i_din.speed_up & !i_din.slow_down, e_fz & i_din.slow_down};
      chk(g, e);
      chk(16'(o_cmd.trip_reset), 16'(rise));
      e = i_link_ok ? sw_of(i_state, e_st) : 16'h0000;
      chk(o_state_word, e);
      a = x[16] ? STATE_WORD_REG : x[31:16];
      exp_q.push_back((a == STATE_WORD_REG && i_link_ok) ?
        sw_of(i_state, e_st) : 16'h0000);
      i_dcsw_master.read(a);
    end
    repeat (3) @(posedge i_sys_clk);
    wrap_up();
  end
endmodule : test_drive_control_status_word
bind dcsw_top dcsw_properties i_dcsw_properties (.i_sys_clk, .i_rst,
  .i_cmd_wr, .i_cmd_word, .i_reg_addr, .i_reg_rd, .i_cfg, .i_state,
  .i_link_ok, .o_cmd, .o_state_word, .o_rd_data, .o_rd_valid);
